// file: hcw_pkg.sv
// ----------------------------------------------------------------
// Shared constants and types of the code word builder
// ----------------------------------------------------------------
package hcw_pkg;

   // ----------------------------------------------------------------
   // Parameter store map (word indices)
   // ----------------------------------------------------------------
   localparam int          STORE_WORDS  = 12;       // Twelve 16-bit words
   localparam int          WORD_W       = 16;       // Width of one stored word
   localparam logic [3:0]  ADDR_KEY0    = 4'h0;     // Lowest key word
   localparam logic [3:0]  ADDR_KEY1    = 4'h1;
   localparam logic [3:0]  ADDR_KEY2    = 4'h2;
   localparam logic [3:0]  ADDR_KEY3    = 4'h3;     // Highest key word
   localparam logic [3:0]  ADDR_HOPCNT  = 4'h4;     // Hop counter word
   localparam logic [3:0]  ADDR_UNUSED  = 4'h5;     // Loaded with zero by programmer
   localparam logic [3:0]  ADDR_SER_LO  = 4'h6;
   localparam logic [3:0]  ADDR_SER_HI  = 4'h7;
   localparam logic [3:0]  ADDR_SEED_LO = 4'h8;
   localparam logic [3:0]  ADDR_SEED_HI = 4'h9;
   localparam logic [3:0]  ADDR_CHECK   = 4'hA;     // Discrimination bits
   localparam logic [3:0]  ADDR_OPTION  = 4'hB;     // Option word
   localparam logic [3:0]  ADDR_LAST    = 4'hB;     // Highest valid index
   localparam logic [15:0] STORE_RESET  = 16'h0000; // Power-on content

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int OPT_S3SET_BIT = 8;  // Fourth button bit forced high
   localparam int OPT_XSER_BIT  = 9;  // Full 32-bit serial number sent
   localparam int CHECK_W       = 12; // Used discrimination bits
   localparam int SERIAL_STD_W  = 28; // Serial bits in standard format
   localparam int HOP_W         = 32; // Hopping portion width
   localparam int CODE_W        = 66; // Whole code word width

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ       = 25_000_000; // core_clk rate
   localparam int DEBOUNCE_MS  = 10;         // Debounce wait
   localparam int DEBOUNCE_CYC = (CLK_HZ / 1000) * DEBOUNCE_MS;
   localparam int DEB_CNT_W    = 20;         // Holds DEBOUNCE_CYC

   // ----------------------------------------------------------------
   // Cipher constants
   // ----------------------------------------------------------------
   localparam logic [31:0] NLF_TABLE   = 32'h1E5AC3B7; // Nonlinear function, arbitrary pattern
   localparam int          CIPHER_RNDS = 512;          // Rounds per block, plain default
   localparam int          RND_W       = 10;           // Round counter width

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   // Gray coded along sleep, debounce, load, crypt, push, hold
   typedef enum logic [2:0] {
      ST_SLEEP = 3'h0,
      ST_DEB   = 3'h1,
      ST_LOAD  = 3'h3,
      ST_CRYPT = 3'h2,
      ST_PUSH  = 3'h6,
      ST_HOLD  = 3'h7
   } hcw_state_t;

   // Code word as it leaves the block, hopping part in the low bits
   typedef struct packed {
      logic [1:0]  status;  // {low battery, counter wrapped}
      logic [31:0] fixed;   // Serial number, with button bits in standard format only
      logic [31:0] hop;     // Encrypted part or seed
   } hcw_code_word_t;

   // Parameter store write request
   typedef struct packed {
      logic        we;
      logic [3:0]  addr;
      logic [15:0] data;
   } hcw_prog_t;

endpackage

// file: hcw_builder.sv
`timescale 1ns/1ns

// ----------------------------------------------------------------
// Code word FIFO between builder and RF framer
// ----------------------------------------------------------------
module hcw_fifo
   import hcw_pkg::*;
#(
   parameter int WIDTH = CODE_W,
   parameter int DEPTH = 8
)
(
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   // All FIFO state in one record
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;   // Storage
      logic [AW-1:0]               wr;    // Write index
      logic [AW-1:0]               rd;    // Read index
      logic [AW:0]                 cnt;   // Fill level
      logic                        vld;   // Head valid, kept in a flop for the output
      logic [WIDTH-1:0]            head;  // Head word, kept in a flop for the output
   } hcw_fifo_st_t;

   hcw_fifo_st_t s_r;   // Registered state
   hcw_fifo_st_t s_nxt; // Next state

   logic push;          // Accepted write
   logic pop;           // Accepted read

   // ----------------------------------------------------------------
   // Handshakes; full and empty come from the fill level
   // ----------------------------------------------------------------
   assign in_ready  = (s_r.cnt != (AW+1)'(DEPTH));
   assign out_valid = s_r.vld;
   assign out_data  = s_r.head;
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Next state
   always_comb
   begin
      s_nxt = s_r;
      if (push)
      begin
         s_nxt.mem[s_r.wr] = in_data;
         s_nxt.wr          = (s_r.wr == AW'(DEPTH-1)) ? '0 : s_r.wr + 1'b1;
      end
      if (pop)
         s_nxt.rd = (s_r.rd == AW'(DEPTH-1)) ? '0 : s_r.rd + 1'b1;
      // Simultaneous push and pop leave the level alone
      if (push && !pop)
         s_nxt.cnt = s_r.cnt + 1'b1;
      else if (pop && !push)
         s_nxt.cnt = s_r.cnt - 1'b1;
      s_nxt.vld  = (s_nxt.cnt != '0);
      s_nxt.head = s_nxt.mem[s_nxt.rd];
   end

   // State register
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end
endmodule

// ----------------------------------------------------------------
// Code hopping word builder, top level
// ----------------------------------------------------------------
module hcw_builder
   import hcw_pkg::*;
#(
   parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC, // Shorten in simulation
   parameter int FIFO_DEPTH      = 8
)
(
   input  wire logic             core_clk,
   input  wire logic             resetn,
   input  wire logic             button_in0,
   input  wire logic             button_in1,
   input  wire logic             button_in2,
   input  wire logic             vlow_in,
   input  wire hcw_prog_t        prog,
   output logic                  awake,
   output logic                  word_valid,
   input  wire logic             word_ready,
   output hcw_code_word_t        word_data
);

   // ----------------------------------------------------------------
   // State record
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [STORE_WORDS-1:0][WORD_W-1:0] store;   // Parameter store
      logic [2:0]             btn_meta;  // First sync stage
      logic [2:0]             btn_sync;  // Second sync stage
      logic                   vlow_meta; // First sync stage
      logic                   vlow_sync; // Second sync stage
      hcw_state_t             state;     // Sequencer
      logic [DEB_CNT_W-1:0]   deb_cnt;   // Debounce timer
      logic [2:0]             btn_lat;   // Buttons sampled for this word
      logic [31:0]            blk;       // Cipher block register
      logic [RND_W-1:0]       rnd;       // Cipher round number
      logic                   wrapped;   // Counter has passed all-ones
      hcw_code_word_t         word;      // Word being built
      logic                   awake;     // Output copy
   } hcw_st_t;

   hcw_st_t        s_r;          // Registered state
   hcw_st_t        s_nxt;        // Next state
   logic [1:0]     rst_sync_r;   // Reset release synchroniser
   logic           rst_n;        // Synchronised reset
   logic           fifo_ready;   // FIFO can take a word
   logic [63:0]    key;          // Cipher key view of the store
   logic [3:0]     btn_code;     // Four button bits of this word
   logic           added_btn;    // A button not in the latch is pressed
   logic           any_btn;      // Any button still held
   logic [4:0]     nlf_idx;      // Nonlinear function index
   logic           fb_bit;       // Cipher feedback bit
   logic [15:0]    cnt_inc;      // Incremented hop counter
   logic [CODE_W-1:0] fifo_out;  // Flat FIFO output

   // ----------------------------------------------------------------
   // Reset release: asserted at once, released after two edges
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         rst_sync_r <= 2'h0;
      else
         rst_sync_r <= {rst_sync_r[0], 1'b1};
   end
   assign rst_n = rst_sync_r[1];

   // ----------------------------------------------------------------
   // Derived values
   // ----------------------------------------------------------------
   // key word 0 lowest
   assign key = {s_r.store[ADDR_KEY3], s_r.store[ADDR_KEY2],
                 s_r.store[ADDR_KEY1], s_r.store[ADDR_KEY0]};

   // Fourth bit either forced or a copy of the third button
   assign btn_code = {s_r.store[ADDR_OPTION][OPT_S3SET_BIT] | s_r.btn_lat[2],
                      s_r.btn_lat};

   assign added_btn = |(s_r.btn_sync & ~s_r.btn_lat);
   assign any_btn   = |s_r.btn_sync;

   assign cnt_inc = s_r.store[ADDR_HOPCNT] + 16'h0001;

   assign nlf_idx = {s_r.blk[31], s_r.blk[26], s_r.blk[20], s_r.blk[9], s_r.blk[1]};
   assign fb_bit  = NLF_TABLE[nlf_idx] ^ s_r.blk[16] ^ s_r.blk[0]
                    ^ key[s_r.rnd[5:0]];

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      s_nxt           = s_r;
      // Pins pass two flops before use
      s_nxt.btn_meta  = {button_in2, button_in1, button_in0};
      s_nxt.btn_sync  = s_r.btn_meta;
      s_nxt.vlow_meta = vlow_in;
      s_nxt.vlow_sync = s_r.vlow_meta;

      // programming only while asleep, twelve words
      if (prog.we && (prog.addr <= ADDR_LAST) && (s_r.state == ST_SLEEP))
      begin
         s_nxt.store[prog.addr] = prog.data;
      end

      case (s_r.state)
         // Asleep until any button goes active
         ST_SLEEP:
         begin
            if (any_btn)
            begin
               s_nxt.state   = ST_DEB;
               s_nxt.deb_cnt = '0;
            end
         end

         ST_DEB:
         begin
            if (!any_btn)
            begin
               // Bounce only; back to sleep
               s_nxt.state = ST_SLEEP;
            end
            else if (s_r.deb_cnt == DEB_CNT_W'(DEBOUNCE_CYCLES - 1))
            begin
               s_nxt.state = ST_LOAD;
            end
            else
            begin
               s_nxt.deb_cnt = s_r.deb_cnt + 1'b1;
            end
         end

         // sample buttons and advance counter before encryption
         ST_LOAD:
         begin
            s_nxt.btn_lat = s_r.btn_sync;
            // counter advanced and kept in the store
            s_nxt.store[ADDR_HOPCNT] = cnt_inc;
            // wrap recorded and sent as status
            if (cnt_inc == 16'h0000)
            begin
               s_nxt.wrapped = 1'b1;
            end
            // plaintext: buttons, 12 check bits, counter
            s_nxt.blk = {s_r.store[ADDR_OPTION][OPT_S3SET_BIT] | s_r.btn_sync[2],
                         s_r.btn_sync,
                         s_r.store[ADDR_CHECK][CHECK_W-1:0],
                         cnt_inc};
            s_nxt.rnd   = '0;
            s_nxt.state = ST_CRYPT;
         end

         ST_CRYPT:
         begin
            if (added_btn)
            begin
               s_nxt.state   = ST_DEB;
               s_nxt.deb_cnt = '0;
            end
            else
            begin
               s_nxt.blk = {fb_bit, s_r.blk[31:1]};
               s_nxt.rnd = s_r.rnd + 1'b1;
               if (s_r.rnd == RND_W'(CIPHER_RNDS - 1))
               begin
                  // assemble 32 hop plus 34 fixed bits
                  s_nxt.word.status = {s_r.vlow_sync, s_r.wrapped};
                  // standard format sends 28 serial bits
                  s_nxt.word.fixed  = s_r.store[ADDR_OPTION][OPT_XSER_BIT] ?
                     {s_r.store[ADDR_SER_HI], s_r.store[ADDR_SER_LO]} :
                     {btn_code, s_r.store[ADDR_SER_HI][11:0], s_r.store[ADDR_SER_LO]};
                  // all three buttons send the seed
                  s_nxt.word.hop = (&s_r.btn_lat) ?
                     {s_r.store[ADDR_SEED_HI], s_r.store[ADDR_SEED_LO]} :
                     {fb_bit, s_r.blk[31:1]};
                  s_nxt.state = ST_PUSH;
               end
            end
         end

         // Hand the word to the FIFO; stalls while it is full
         ST_PUSH:
         begin
            if (added_btn)
            begin
               // abandon word not yet handed over
               s_nxt.state   = ST_DEB;
               s_nxt.deb_cnt = '0;
            end
            else if (fifo_ready)
            begin
               s_nxt.state = ST_HOLD;
            end
         end

         // Word delivered: repeat while held, else power down
         ST_HOLD:
         begin
            if (added_btn)
            begin
               s_nxt.state   = ST_DEB;
               s_nxt.deb_cnt = '0;
            end
            // partial release keeps the same word
            else if (any_btn)
            begin
               s_nxt.state = ST_PUSH;
            end
            else
            begin
               s_nxt.state = ST_SLEEP;
            end
         end

         default:
         begin
            s_nxt.state = ST_SLEEP;
         end
      endcase

      s_nxt.awake = (s_nxt.state != ST_SLEEP);
   end

   // ----------------------------------------------------------------
   // State register; the store clears only at power-on reset
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_r       <= '0;
         s_r.store <= {STORE_WORDS{STORE_RESET}};
         s_r.state <= ST_SLEEP;
      end
      else
         s_r <= s_nxt;
   end

   // ----------------------------------------------------------------
   // Output FIFO; a full FIFO holds the builder in its push state
   // ----------------------------------------------------------------
   hcw_fifo #(
      .WIDTH (CODE_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .in_valid  (s_r.state == ST_PUSH && !added_btn),
      .in_ready  (fifo_ready),
      .in_data   (s_r.word),
      .out_valid (word_valid),
      .out_ready (word_ready),
      .out_data  (fifo_out)
   );

   assign word_data = hcw_code_word_t'(fifo_out);
   assign awake     = s_r.awake;

endmodule

// file: hcw_monitor.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Port checker of the code word builder
// ----------------------------------------------------------------
module hcw_monitor
   import hcw_pkg::*;
#(
   parameter int DEBOUNCE_CYCLES = 4
)
(
   input wire logic           core_clk,
   input wire logic           resetn,
   input wire logic           button_in0,
   input wire logic           button_in1,
   input wire logic           button_in2,
   input wire logic           vlow_in,
   input wire hcw_prog_t      prog,
   input wire logic           awake,
   input wire logic           word_valid,
   input wire logic           word_ready,
   input wire hcw_code_word_t word_data
);
   wire logic  any_btn = button_in0 | button_in1 | button_in2; // Any pin pressed
   logic [11:0] wake_cnt_r;                                     // Cycles awake, saturating

   // Awake time; saturates so a long hold never wraps to a small value
   always_ff @(posedge core_clk or negedge resetn)
      if (!resetn)
         wake_cnt_r <= 12'h000;
      else if (!awake)
         wake_cnt_r <= 12'h000;
      else if (wake_cnt_r != 12'hFFF)
         wake_cnt_r <= wake_cnt_r + 12'h001;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   a_press_wakes: assert property (!awake && any_btn ##1 any_btn [*2] |-> ##[0:2] awake)
      else $error("held press did not wake the block");
   a_no_idle_wake: assert property (!any_btn [*4] ##1 !awake |=> !awake)
      else $error("woke without a button");
   a_wake_cause: assert property ($rose(awake) |-> $past(any_btn, 2) || $past(any_btn, 3))
      else $error("wake not preceded by a press");
   a_crypt_time: assert property ($rose(word_valid) && awake |-> wake_cnt_r >= DEBOUNCE_CYCLES + CIPHER_RNDS)
      else $error("word came before debounce and cipher");
   a_word_bound: assert property ($rose(awake) ##1 (awake && any_btn) [*8] |-> ##[1:700] word_valid)
      else $error("no word after a held press");
   a_asleep_quiet: assert property (!awake [*3] |-> !$rose(word_valid))
      else $error("new word while asleep");
   a_head_hold: assert property (word_valid && !word_ready |=> word_valid && $stable(word_data))
      else $error("buffer head moved without a pop");
   a_release_sleeps: assert property (awake ##0 !any_btn [*4] |-> ##[0:700] !awake)
      else $error("no power down after release");

   c_seed: cover property (awake && button_in0 && button_in1 && button_in2);
   c_stall: cover property (word_valid && !word_ready [*8]);
   c_done: cover property ($fell(awake) ##1 word_valid);
endmodule

bind hcw_builder hcw_monitor #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) mon (.core_clk(core_clk),
   .resetn(resetn), .button_in0(button_in0), .button_in1(button_in1), .button_in2(button_in2),
   .vlow_in(vlow_in), .prog(prog), .awake(awake), .word_valid(word_valid),
   .word_ready(word_ready), .word_data(word_data));

// file: hcw_rf_sink.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Radio stage stand-in: takes words, promptly or slowly
// ----------------------------------------------------------------
module hcw_rf_sink
   import hcw_pkg::*;
(
   input  wire logic           core_clk,
   input  wire logic           stall,      // Hold ready low while set
   input  wire logic           word_valid,
   input  wire hcw_code_word_t word_data,
   output logic                word_ready,
   output logic                got,        // One cycle per word taken
   output hcw_code_word_t      got_word    // Word taken at that edge
);
   initial
   begin
      word_ready = 1'b0;
      got = 1'b0;
      got_word = '0;
   end

   // Ready moves after the falling edge; one cycle in four it lags
   always @(negedge core_clk)
      word_ready <= !stall && ($urandom_range(3) != 0);

   always @(posedge core_clk)
   begin
      got <= word_valid && word_ready;
      got_word <= word_data;
   end
endmodule

// file: testbench.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Self-checking bench of the code word builder
// ----------------------------------------------------------------
module testbench
   import hcw_pkg::*;
;
   localparam int  DEB   = 4;     // Short debounce keeps the run brief
   localparam int  LIMIT = 20000; // Cycle ceiling for a hang
   logic           core_clk, resetn, vlow_in, awake, word_valid, word_ready;
   logic           button_in0, button_in1, button_in2, stall, got, rep_ok, wrapped;
   hcw_prog_t      prog;
   hcw_code_word_t word_data, got_word, last;
   hcw_code_word_t notes[$];   // Expected words, oldest first
   logic [15:0]    mem[0:11];  // Shadow of the parameter store
   int             err_count, checks, cycles;
   logic [31:0]    plain;      // Hop part undone as a receiver would

   hcw_builder #(.DEBOUNCE_CYCLES(DEB), .FIFO_DEPTH(8)) dut (.core_clk(core_clk),
      .resetn(resetn), .button_in0(button_in0), .button_in1(button_in1),
      .button_in2(button_in2), .vlow_in(vlow_in), .prog(prog), .awake(awake),
      .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data));
   hcw_rf_sink rf (.core_clk(core_clk), .stall(stall), .word_valid(word_valid),
      .word_data(word_data), .word_ready(word_ready), .got(got), .got_word(got_word));

   always #20 core_clk = ~core_clk;

   task automatic tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   task automatic chk(input string what, input logic [65:0] exp, input logic [65:0] seen);
      checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Store write; the shadow follows only where the write should land
   task automatic wr(input logic [3:0] a, input logic [15:0] d, input bit ok);
      prog = '{we: 1'b1, addr: a, data: d};
      tick(1);
      prog.we = 1'b0;
      tick(1);
      if (ok && a <= ADDR_LAST)
         mem[a] = d;
   endtask

   // Reference cipher, written from the round description
   function automatic logic [31:0] enc(input logic [31:0] p, input logic [63:0] k);
      logic [31:0] x;
      logic        b;
      x = p;
      for (int i = 0; i < CIPHER_RNDS; i++)
      begin
         b = NLF_TABLE[{x[31], x[26], x[20], x[9], x[1]}] ^ x[16] ^ x[0] ^ k[i % 64];
         x = {b, x[31:1]};
      end
      return x;
   endfunction

   // receiver side: rounds run backwards to recover the plaintext
   function automatic logic [31:0] dec(input logic [31:0] c, input logic [63:0] k);
      logic [31:0] x;
      logic        b;
      x = c;
      for (int i = CIPHER_RNDS - 1; i >= 0; i--)
      begin
         b = x[31] ^ NLF_TABLE[{x[30], x[25], x[19], x[8], x[0]}] ^ x[15] ^ k[i % 64];
         x = {x[30:0], b};
      end
      return x;
   endfunction

   function automatic void bump();
      mem[4] = mem[4] + 16'h0001;
      if (mem[4] == 16'h0000)
         wrapped = 1'b1;
   endfunction

   // Expected word for one activation
   task automatic note(input logic [2:0] b);
      logic [3:0]     s;
      hcw_code_word_t w;
      bump();
      s = {mem[11][OPT_S3SET_BIT] | b[2], b};
      w.status = {vlow_in, wrapped};
      w.fixed = mem[11][OPT_XSER_BIT] ? {mem[7], mem[6]} : {s, mem[7][11:0], mem[6]};
      w.hop = (b == 3'h7) ? {mem[9], mem[8]} :
         enc({s, mem[10][CHECK_W-1:0], mem[4]}, {mem[3], mem[2], mem[1], mem[0]});
      notes.push_back(w);
   endtask

   // Mode 0 plain, 1 released in debounce, 2 added button, 3 held into a full buffer
   task automatic press(input logic [2:0] b, input int mode);
      vlow_in = 1'($urandom);
      {button_in2, button_in1, button_in0} = b;
      tick(4);
      chk("awake", 1'b1, awake);
      if (mode == 1)
         {button_in2, button_in1, button_in0} = 3'h0;
      else
      begin
         tick(16);
         if (mode == 2)
         begin
            wr(ADDR_SER_LO, ~mem[6], 1'b0);
            bump();
            b = b | 3'h2;
            {button_in2, button_in1, button_in0} = b;
            tick(20);
         end
         note(b);
         if (mode == 3)
         begin
            tick(600);
            chk("held word", 1'b1, word_valid);
            repeat (7) notes.push_back(notes[$]);
            rep_ok = 1'b1;
         end
         {button_in2, button_in1, button_in0} = b & (b - 3'h1);
         tick(10);
         {button_in2, button_in1, button_in0} = 3'h0;
         stall = 1'b0;
      end
      for (int n = 0; n < 3000 && awake !== 1'b0; n++)
         tick(1);
      chk("asleep", 1'b0, awake);
   endtask

   task automatic drain();
      for (int n = 0; n < 300 && word_valid !== 1'b0; n++)
         tick(1);
      tick(2);
   endtask

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Words taken are matched against the oldest note; with none left, repeats against the last note taken
   always @(posedge core_clk)
      if (got === 1'b1)
      begin
         if (notes.size() > 0)
         begin
            last = notes.pop_front();
            chk("code word", last, got_word);
            plain = dec(got_word.hop, {mem[3], mem[2], mem[1], mem[0]});
            if (last.hop != {mem[9], mem[8]})
               chk("check bits", 66'(mem[10][CHECK_W-1:0]), 66'(plain[27:16]));
         end
         else if (rep_ok)
            chk("repeat word", last, got_word);
         else
            chk("spare word", 1'b0, 1'b1);
      end

   // Hang guard
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         err_count++;
         end_of_test();
      end
   end

   initial
   begin
      core_clk = 1'b0;
      resetn = 1'b0;
      {button_in2, button_in1, button_in0} = 3'h0;
      {vlow_in, stall, rep_ok, wrapped} = 4'h0;
      prog = '0;
      void'($urandom(32'hCED3));
      tick(6);
      resetn = 1'b1;
      tick(3);
      chk("idle", 2'h0, {awake, word_valid});
      for (int i = 0; i < STORE_WORDS; i++)
         wr(4'(i), (i == 5) ? 16'h0000 : 16'($urandom), 1'b1);
      wr(ADDR_HOPCNT, 16'hFFFE, 1'b1);
      // check bits from serial, junk above bit 11
      wr(ADDR_CHECK, {4'($urandom), mem[6][11:0]}, 1'b1);
      wr(4'hC, 16'hFFFF, 1'b1);
      for (int i = 1; i < 8; i++)
      begin
         wr(ADDR_OPTION, {6'($urandom), 2'(i), 8'($urandom)}, 1'b1);
         press(3'(i), 0);
      end
      press(3'h2, 1);
      press(3'h1, 2);
      drain();
      stall = 1'b1;
      press(3'h4, 3);
      drain();
      chk("notes left", 66'h0, 66'(notes.size()));
      end_of_test();
   end
endmodule
